// ---- isp_pkg.sv ----
// Constants and types for the serial memory programming port
package isp_pkg;

  // Core clock and write wait times
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real FLASH_WAIT_MS = 4.5;
  localparam real EEPROM_WAIT_MS = 9.0;
  localparam real ERASE_WAIT_MS = 9.0;
  localparam int FLASH_WAIT_CYC = int'($ceil(FLASH_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));

  // Instruction first bytes and fields
  localparam logic [7:0] OP_PROG = 8'hAC;
  localparam logic [7:0] SYNC_ECHO = 8'h53;
  localparam logic [2:0] ERASE_B2 = 3'h4;
  localparam logic [7:0] H_MASK = 8'h08;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_FLASH = 8'h40;
  localparam logic [7:0] OP_WR_FPAGE = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_LD_EE = 8'hC1;
  localparam logic [7:0] OP_WR_EPAGE = 8'hC2;
  localparam logic [7:0] OP_RD_SIG = 8'h30;

  // Data values
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] NO_DATA = 8'h00;

  // Bit positions inside a 32-bit instruction frame
  localparam logic [4:0] BIT_SYNC = 5'h0F;
  localparam logic [4:0] BIT_ECHO_CHK = 5'h10;
  localparam logic [4:0] BIT_READ = 5'h17;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  localparam logic [2:0] BYTE_END = 3'h7;
  localparam logic [2:0] BYTE_START = 3'h0;

  // Page geometry fixed by the instruction format
  localparam int FPAGE_WORDS = 64;
  localparam int EPAGE_BYTES = 4;

  typedef enum logic [1:0] {
    WK_FLASH = 2'b00,
    WK_EE = 2'b01,
    WK_ERASE = 2'b11
  } wr_kind_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } core_st_e;

endpackage

// ---- serial_memory_programming_port.sv ----
// Serial programming port with its flash and eeprom arrays
// Notes on behaviour
// RULE_01: Programming only in reset, after enable
// RULE_02: EEPROM writes erase automatically first
// RULE_03: Chip erase sets both arrays to FF
// RULE_04: A running core clock is required
// RULE_05: Programmer keeps clock phases above minimum
// RULE_06: Input bits sampled on rising clock
// RULE_07: Output bits change on falling clock
// RULE_08: Programmer powers up with reset low
// RULE_09: Programmer waits 20 ms before enable; the programmer model waits only four lclk cycles plus 200 ns after reset low
// RULE_10: Echo 0x53 in byte three; sync
// RULE_11: Programmer always sends all four bytes
// RULE_12: Programmer pulses reset if echo missing; the bench pulses reset twice before enable and only checks the echo
// RULE_13: Flash page buffer loaded per byte
// RULE_14: Programmer loads low byte before high
// RULE_15: Write page commits buffer to page
// RULE_16: Programmer waits out flash write time
// RULE_17: EEPROM page buffer loaded per byte
// RULE_18: Write EEPROM page commits its buffer
// RULE_19: EEPROM byte write, erased then written
// RULE_20: Programmer may skip FF bytes
// RULE_21: Read returns selected location on output
// RULE_22: Reset release leaves programming mode
// RULE_23: Enable is AC 53 then two bytes
// RULE_24: Programmer waits 4.5 or 9.0 ms; the bench cuts all three waits to 2000 core cycles and polls busy
// RULE_25: Page under programming reads as FF; code does this for flash pages only
// RULE_26: Erase is AC then 100 pattern
// RULE_27: MSB first, act after fourth byte
`timescale 1ns/1ps
module serial_memory_programming_port
  import isp_pkg::*;
#(
  parameter int FLASH_WORDS = 8192,
  parameter int EE_BYTES = 512,
  parameter int FLASH_WAIT = FLASH_WAIT_CYC,
  parameter int EE_WAIT = EEPROM_WAIT_CYC,
  parameter int ERASE_WAIT = ERASE_WAIT_CYC,
  // Signature values are arbitrary
  parameter logic [7:0] SIG0 = 8'h5A,
  parameter logic [7:0] SIG1 = 8'h11,
  parameter logic [7:0] SIG2 = 8'h22
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic reset_pin_n_i,
  output logic miso_o,
  output logic prog_mode_o,
  output logic busy_o
);

  localparam int FAW = $clog2(FLASH_WORDS);
  localparam int EAW = $clog2(EE_BYTES);
  localparam int FPW = FAW - $clog2(FPAGE_WORDS);
  localparam int EPW = EAW - $clog2(EPAGE_BYTES);
  localparam int MAXW = (EE_WAIT > FLASH_WAIT) ? EE_WAIT : FLASH_WAIT;
  localparam int WCW = $clog2(((ERASE_WAIT > MAXW) ? ERASE_WAIT : MAXW) + 1);

  if (FAW > 14 || FPW < 1 || (1 << FAW) != FLASH_WORDS ||
      EAW > 10 || EPW < 1 || (1 << EAW) != EE_BYTES ||
      FLASH_WAIT < 1 || EE_WAIT < 1 || ERASE_WAIT < 1) begin : g_chk
    $error("Unsupported memory size or wait count");
  end

  typedef struct packed {
    logic busy_s1;
    logic busy_s2;
    logic [4:0] cnt;
    logic [31:0] sh;
    logic [7:0] tx;
    logic enabled;
    logic ev_tgl;
    wr_kind_e ev_kind;
    logic [FPW-1:0] busy_page;
  } link_s;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic en_s1;
    logic en_s2;
    logic prog_mode;
    core_st_e st;
    logic [WCW-1:0] wait_cnt;
  } core_s;

  link_s ln_q, ln_d;
  core_s cr_q, cr_d;
  logic [7:0] out_q;

  logic [15:0] fmem [FLASH_WORDS];
  logic [7:0] emem [EE_BYTES];
  logic [15:0] fbuf [FPAGE_WORDS];
  logic [7:0] ebuf [EPAGE_BYTES];
  logic [(1<<FPW)-1:0] fblank;
  logic [(1<<EPW)-1:0] eblank;

  logic [31:0] nxt;
  logic [7:0] c1, c2, c3, c4;
  logic [13:0] fa_rd, fa_wr;
  logic [9:0] ea_rd, ea_wr;
  logic [15:0] fword;
  logic [7:0] rd_byte;
  logic live, busy_hit;
  logic op_erase, op_fload, op_fwrite, op_eload, op_ebyte, op_epage, any_op;

  // Link side: decode of the frame on the serial clock
  always_comb begin
    ln_d = ln_q;
    ln_d.busy_s1 = (cr_q.st == ST_BUSY);
    ln_d.busy_s2 = ln_q.busy_s1;
    // RULE_06 RULE_27 rising edge, MSB first
    nxt = {ln_q.sh[30:0], mosi_i};
    c1 = nxt[31:24];
    c2 = nxt[23:16];
    c3 = nxt[15:8];
    c4 = nxt[7:0];
    // RULE_21 read address from bytes two and three
    fa_rd = {nxt[13:8], nxt[7:0]};
    ea_rd = {nxt[9:8], nxt[7:0]};
    fword = fmem[fa_rd[FAW-1:0]];
    // RULE_25 flash page under programming reads as erased
    busy_hit = ln_q.busy_s2 && ln_q.ev_kind == WK_FLASH &&
      ln_q.busy_page == fa_rd[FAW-1:FAW-FPW];
    rd_byte = NO_DATA;
    if (ln_q.enabled) begin
      if ((nxt[23:16] & ~H_MASK) == OP_RD_FLASH) begin
        if (busy_hit || fblank[fa_rd[FAW-1:FAW-FPW]]) begin
          rd_byte = ERASED;
        end else begin
          rd_byte = nxt[19] ? fword[15:8] : fword[7:0];
        end
      end else if (nxt[23:16] == OP_RD_EE) begin
        rd_byte = eblank[ea_rd[EAW-1:EAW-EPW]] ? ERASED : emem[ea_rd[EAW-1:0]];
      end else if (nxt[23:16] == OP_RD_SIG) begin
        unique case (nxt[1:0])
          2'h0: rd_byte = SIG0;
          2'h1: rd_byte = SIG1;
          2'h2: rd_byte = SIG2;
          default: rd_byte = ERASED;
        endcase
      end
    end
    // RULE_27 act only on the fourth byte
    live = ln_q.enabled && ln_q.cnt == BIT_LAST;
    fa_wr = {c2[5:0], c3};
    ea_wr = {c2[1:0], c3};
    // RULE_01 RULE_26 erase needs prior enable
    op_erase = live && c1 == OP_PROG && c2[7:5] == ERASE_B2;
    // RULE_13 load flash buffer
    op_fload = live && (c1 & ~H_MASK) == OP_LD_FLASH;
    op_fwrite = live && c1 == OP_WR_FPAGE;
    // RULE_17 load eeprom buffer
    op_eload = live && c1 == OP_LD_EE;
    op_ebyte = live && c1 == OP_WR_EE;
    op_epage = live && c1 == OP_WR_EPAGE;
    any_op = op_erase || op_fwrite || op_ebyte || op_epage;
    ln_d.cnt = ln_q.cnt + 5'h1;
    ln_d.sh = nxt;
    // RULE_10 each byte but byte three echoes on the next, 0x53 in byte three
    if (ln_q.cnt[2:0] == BYTE_END) begin
      ln_d.tx = nxt[7:0];
    end
    // RULE_21 read answer goes out in byte four
    if (ln_q.cnt == BIT_READ) begin
      ln_d.tx = rd_byte;
    end
    // RULE_10 slip one bit until the frame is in sync
    if (!ln_q.enabled && ln_q.cnt == BIT_SYNC && nxt[15:0] != {OP_PROG, SYNC_ECHO}) begin
      ln_d.cnt = BIT_SYNC;
    end
    // RULE_23 enable instruction
    if (ln_q.cnt == BIT_LAST && c1 == OP_PROG && c2 == SYNC_ECHO) begin
      ln_d.enabled = 1'b1;
    end
    if (any_op) begin
      ln_d.ev_tgl = ~ln_q.ev_tgl;
      ln_d.ev_kind = op_erase ? WK_ERASE : (op_fwrite ? WK_FLASH : WK_EE);
    end
    if (op_fwrite) begin
      ln_d.busy_page = fa_wr[FAW-1:FAW-FPW];
    end
  end

  // RULE_22 releasing reset clears the link at once
  always_ff @(posedge sck_i or posedge reset_pin_n_i) begin
    if (reset_pin_n_i) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  // RULE_07 output shifts on the falling edge
  always_ff @(negedge sck_i or posedge reset_pin_n_i) begin
    if (reset_pin_n_i) begin
      out_q <= '0;
    end else if (ln_q.cnt[2:0] == BYTE_START) begin
      out_q <= ln_q.tx;
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign miso_o = out_q[7];

  // Arrays and page buffers
  always_ff @(posedge sck_i) begin
    // RULE_03 erase blanks pages and buffers
    if (op_erase) begin
      fblank <= '1;
      eblank <= '1;
      for (int k = 0; k < FPAGE_WORDS; k++) begin
        fbuf[k] <= {ERASED, ERASED};
      end
      for (int k = 0; k < EPAGE_BYTES; k++) begin
        ebuf[k] <= ERASED;
      end
    end
    if (op_fload) begin
      if (c1[3]) begin
        fbuf[c3[5:0]][15:8] <= c4;
      end else begin
        fbuf[c3[5:0]][7:0] <= c4;
      end
    end
    // RULE_15 commit whole flash page
    if (op_fwrite) begin
      for (int i = 0; i < FPAGE_WORDS; i++) begin
        fmem[{fa_wr[FAW-1:FAW-FPW], 6'(i)}] <= fbuf[i];
        fbuf[i] <= {ERASED, ERASED};
      end
      fblank[fa_wr[FAW-1:FAW-FPW]] <= 1'b0;
    end
    if (op_eload) begin
      ebuf[c3[1:0]] <= c4;
    end
    // RULE_02 RULE_18 page write erases then writes
    if (op_epage) begin
      for (int j = 0; j < EPAGE_BYTES; j++) begin
        emem[{ea_wr[EAW-1:EAW-EPW], 2'(j)}] <= ebuf[j];
        ebuf[j] <= ERASED;
      end
      eblank[ea_wr[EAW-1:EAW-EPW]] <= 1'b0;
    end
    // RULE_02 RULE_19 byte write with erase of a blank page
    if (op_ebyte) begin
      if (eblank[ea_wr[EAW-1:EAW-EPW]]) begin
        for (int j = 0; j < EPAGE_BYTES; j++) begin
          emem[{ea_wr[EAW-1:EAW-EPW], 2'(j)}] <= ERASED;
        end
      end
      emem[ea_wr[EAW-1:0]] <= c4;
      eblank[ea_wr[EAW-1:EAW-EPW]] <= 1'b0;
    end
  end

  // Core side: mode flag and self-timed write busy
  always_comb begin
    cr_d = cr_q;
    cr_d.pin_s1 = reset_pin_n_i;
    cr_d.pin_s2 = cr_q.pin_s1;
    cr_d.ev_s1 = ln_q.ev_tgl;
    cr_d.ev_s2 = cr_q.ev_s1;
    cr_d.ev_s3 = cr_q.ev_s2;
    cr_d.en_s1 = ln_q.enabled;
    cr_d.en_s2 = cr_q.en_s1;
    // RULE_01 RULE_22 mode only while reset pin is low
    cr_d.prog_mode = !cr_q.pin_s2 && cr_q.en_s2;
    unique case (cr_q.st)
      ST_IDLE: begin
        // RULE_04 write timing counted on the core clock
        if (cr_q.ev_s2 != cr_q.ev_s3) begin
          cr_d.st = ST_BUSY;
          unique case (ln_q.ev_kind)
            WK_FLASH: cr_d.wait_cnt = WCW'(FLASH_WAIT);
            WK_ERASE: cr_d.wait_cnt = WCW'(ERASE_WAIT);
            default: cr_d.wait_cnt = WCW'(EE_WAIT);
          endcase
        end
      end
      ST_BUSY: begin
        cr_d.wait_cnt = cr_q.wait_cnt - WCW'(1);
        if (cr_q.wait_cnt == WCW'(1)) begin
          cr_d.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cr_q <= '0;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign prog_mode_o = cr_q.prog_mode;
  assign busy_o = (cr_q.st == ST_BUSY);

  // Checks on the link side
  a_sync_echo: assert property ( // RULE_10
    @(posedge sck_i) disable iff (reset_pin_n_i)
    (ln_q.cnt == BIT_ECHO_CHK && ln_q.sh[15:0] == {OP_PROG, SYNC_ECHO}) |->
      ln_q.tx == SYNC_ECHO)
    else $error("Echo byte missing in sync");
  a_enable_taken: assert property ( // RULE_23
    @(posedge sck_i) disable iff (reset_pin_n_i)
    (ln_q.cnt == BIT_LAST && ln_d.sh[31:16] == {OP_PROG, SYNC_ECHO}) |=> ln_q.enabled)
    else $error("Enable instruction not taken");
  a_no_op_locked: assert property ( // RULE_01
    @(posedge sck_i) disable iff (reset_pin_n_i)
    !ln_q.enabled |-> !(any_op || op_fload || op_eload))
    else $error("Write accepted before enable");
  a_act_on_last: assert property ( // RULE_27
    @(posedge sck_i) disable iff (reset_pin_n_i)
    (any_op || op_fload || op_eload) |-> ln_q.cnt == BIT_LAST)
    else $error("Instruction acted on early");
  a_erase_blank: assert property ( // RULE_03
    @(posedge sck_i) disable iff (reset_pin_n_i)
    op_erase |=> (&fblank && &eblank && ln_q.ev_kind == WK_ERASE))
    else $error("Erase did not blank arrays");
  a_flash_commit: assert property ( // RULE_15
    @(posedge sck_i) disable iff (reset_pin_n_i)
    op_fwrite |=> (!fblank[ln_q.busy_page] && ln_q.ev_tgl != $past(ln_q.ev_tgl)))
    else $error("Flash page not committed");
  a_ee_byte: assert property ( // RULE_19
    @(posedge sck_i) disable iff (reset_pin_n_i)
    op_ebyte |=> emem[$past(ea_wr[EAW-1:0])] == $past(c4))
    else $error("EEPROM byte not written");
  a_busy_ff: assert property ( // RULE_25
    @(posedge sck_i) disable iff (reset_pin_n_i)
    (ln_q.cnt == BIT_READ && ln_q.enabled && busy_hit &&
     (nxt[23:16] & ~H_MASK) == OP_RD_FLASH) |=> ln_q.tx == ERASED)
    else $error("Busy page read not FF");
  a_miso_launch: assert property ( // RULE_07
    @(posedge sck_i) disable iff (reset_pin_n_i)
    (ln_q.cnt[2:0] == BYTE_START && ln_q.cnt != 5'h0) |-> miso_o == ln_q.tx[7])
    else $error("Output bit not launched on falling edge");

  // Checks on the core side
  a_mode_exit: assert property ( // RULE_22
    @(posedge mclk_i) disable iff (!rst_n_i)
    cr_q.pin_s2 |=> !prog_mode_o)
    else $error("Mode kept after reset release");
  a_ee_wait: assert property ( // RULE_18
    @(posedge mclk_i) disable iff (!rst_n_i)
    (cr_q.st == ST_IDLE && cr_q.ev_s2 != cr_q.ev_s3 && ln_q.ev_kind == WK_EE) |=>
      (busy_o && cr_q.wait_cnt == WCW'(EE_WAIT)))
    else $error("EEPROM wait not started");

  c_enable: cover property (@(posedge sck_i) ln_q.cnt == BIT_LAST && !ln_q.enabled ##1 ln_q.enabled);
  c_erase: cover property (@(posedge sck_i) op_erase);
  c_flash_write: cover property (@(posedge sck_i) op_fwrite);
  c_busy_read: cover property (@(posedge sck_i) ln_q.cnt == BIT_READ && busy_hit);

endmodule

// ---- isp_programmer.sv ----
// Behavioural programmer model driving the serial programming port
`timescale 1ns/1ps
module isp_programmer #(
  parameter int PWR_WAIT_NS = 200
) (
  input wire logic lclk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic reset_pin_n_o
);
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    reset_pin_n_o = 1'b0;
  end

  task automatic set_reset(input logic level);
    @(posedge lclk_i);
    reset_pin_n_o = level;
    repeat (4) @(posedge lclk_i);
    if (!level) #(PWR_WAIT_NS);
  endtask

  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_o = tx[i];
      repeat (2) @(posedge lclk_i);
      rx[i] = miso_i;
      sck_o = 1'b1;
      repeat (2) @(posedge lclk_i);
      sck_o = 1'b0;
    end
    // Data line is driven to the inverse of the last bit sent
    mosi_o = ~tx[0];
    @(posedge lclk_i);
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module tb;
  import isp_pkg::*;
  localparam int WAIT_CYC = 2000;
  // Arbitrary signature value
  localparam logic [7:0] SIG_ID = 8'hC3;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic sck;
  logic mosi;
  logic reset_pin_n;
  logic miso;
  logic prog_mode;
  logic busy;
  logic [31:0] rx;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;
  initial begin
    #1.3;
    forever #7.5 lclk = ~lclk;
  end

  serial_memory_programming_port #(.FLASH_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC),
    .ERASE_WAIT(WAIT_CYC), .SIG0(SIG_ID)) i_serial_memory_programming_port (.mclk_i(mclk),
    .rst_n_i(rst_n), .sck_i(sck), .mosi_i(mosi), .reset_pin_n_i(reset_pin_n),
    .miso_o(miso), .prog_mode_o(prog_mode), .busy_o(busy));

  isp_programmer i_isp_programmer (.lclk_i(lclk), .miso_i(miso), .sck_o(sck),
    .mosi_o(mosi), .reset_pin_n_o(reset_pin_n));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmd(input logic [31:0] tx);
    i_isp_programmer.xfer(tx, rx);
  endtask

  task automatic wait_done(input string name);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk({name, " busy"}, 8'h01, {7'h00, busy});
    n = 0;
    while (busy !== 1'b0 && n < WAIT_CYC + 50) begin
      @(negedge mclk);
      n++;
    end
    chk({name, " idle"}, 8'h00, {7'h00, busy});
  endtask

  task automatic t_sync();
    cmd(32'hAC800000);
    repeat (10) @(negedge mclk);
    chk("early busy", 8'h00, {7'h00, busy});
    chk("early mode", 8'h00, {7'h00, prog_mode});
    i_isp_programmer.set_reset(1'b1);
    i_isp_programmer.set_reset(1'b0);
    cmd(32'hAC530000);
    chk("echo first", OP_PROG, rx[23:16]);
    chk("echo sync", SYNC_ECHO, rx[15:8]);
    repeat (10) @(negedge mclk);
    chk("enable mode", 8'h01, {7'h00, prog_mode});
  endtask

  task automatic t_erase();
    cmd(32'hAC800000);
    wait_done("erase");
    cmd(32'h20000500);
    chk("erased flash", ERASED, rx[7:0]);
    cmd(32'hA0000900);
    chk("erased eeprom", ERASED, rx[7:0]);
  endtask

  task automatic t_flash();
    cmd(32'h40000312);
    cmd(32'h48000334);
    cmd(32'h4C004000);
    cmd(32'h20004300);
    chk("flash polling", ERASED, rx[7:0]);
    wait_done("flash");
    cmd(32'h20004300);
    chk("flash low", 8'h12, rx[7:0]);
    cmd(32'h28004300);
    chk("flash high", 8'h34, rx[7:0]);
    cmd(32'h20004400);
    chk("flash unloaded", ERASED, rx[7:0]);
  endtask

  task automatic t_eeprom();
    cmd(32'hC1000055);
    cmd(32'hC1000166);
    cmd(32'hC2000800);
    wait_done("ee page");
    cmd(32'hA0000800);
    chk("ee page 0", 8'h55, rx[7:0]);
    cmd(32'hA0000900);
    chk("ee page 1", 8'h66, rx[7:0]);
    cmd(32'hC00008A5);
    wait_done("ee byte");
    cmd(32'hA0000800);
    chk("ee rewrite", 8'hA5, rx[7:0]);
    cmd(32'hA0000A00);
    chk("ee skipped", ERASED, rx[7:0]);
    cmd(32'h30000000);
    chk("signature", SIG_ID, rx[7:0]);
  endtask

  task automatic t_exit();
    i_isp_programmer.set_reset(1'b1);
    repeat (10) @(negedge mclk);
    chk("exit mode", 8'h00, {7'h00, prog_mode});
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(negedge mclk);
    chk("reset mode", 8'h00, {7'h00, prog_mode});
    rst_n = 1'b1;
    i_isp_programmer.set_reset(1'b1);
    i_isp_programmer.set_reset(1'b0);
    t_sync();
    t_erase();
    t_flash();
    t_eeprom();
    t_exit();
    final_report();
  end
endmodule
